// ==== design/dad_pkg.sv ====
package dad_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_WORD_ADDR  = 8'h04;
  localparam logic [7:0] OFF_WORDS_LEFT = 8'h08;
  localparam logic [7:0] OFF_DISK_ADDR  = 8'h0C;
  localparam logic [7:0] OFF_STATUS     = 8'h10;

  // Control register bit positions.
  localparam int CTRL_MCLR_BIT = 0;
  localparam int CTRL_SRC_BIT  = 1;
  localparam int CTRL_RWC_BIT  = 2;

  // Status register bit positions above the selected 16-bit status word.
  localparam int STAT_TRACK_BIT = 16;
  localparam int STAT_STEP_BIT  = 17;
  localparam int STAT_AERR_BIT  = 18;
  localparam int STAT_ZERO_BIT  = 19;
  localparam int STAT_SEEK_BIT  = 20;

  // Disk address word layout.
  localparam int CYL_HI      = 15;
  localparam int CYL_LO      = 7;
  localparam int SURFACE_BIT = 6;
  localparam int DISK_BIT    = 5;
  localparam int SECT_HI     = 4;
  localparam int SECT_LO     = 0;

  // Field widths.
  localparam int WORD_W = 16;
  localparam int CYL_W  = 9;
  localparam int SECT_W = 5;

  // Reset values.
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [8:0]  CYL_RESET  = 9'h000;
  localparam logic [4:0]  SECT_RESET = 5'h00;

  // Sector count that triggers a track advance.
  localparam logic [4:0] SECT_WRAP = 5'h1D;

  // Highest legal cylinder for a normal and a 100 TPI unit.
  localparam logic [8:0] CYL_LIMIT_STD   = 9'h0CA;
  localparam logic [8:0] CYL_LIMIT_DENSE = 9'h195;

  // Phase sequencer codes, one-hot.
  typedef enum logic [3:0] {
    PH_T1 = 4'b0001,
    PH_T2 = 4'b0010,
    PH_T3 = 4'b0100,
    PH_T4 = 4'b1000
  } dad_phase_t;

endpackage : dad_pkg

// ==== design/dad_phase.sv ====
`timescale 1ns/1ps
module dad_phase (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Phase pulses, each high for one clock.
  output logic      t1,
  output logic      t2,
  output logic      t3,
  output logic      t4
);

  dad_pkg::dad_phase_t phase_q;

  // Step through T1..T4 in a fixed ring, one phase per clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= dad_pkg::PH_T1;
    end else begin
      unique case (phase_q)
        dad_pkg::PH_T1: phase_q <= dad_pkg::PH_T2;
        dad_pkg::PH_T2: phase_q <= dad_pkg::PH_T3;
        dad_pkg::PH_T3: phase_q <= dad_pkg::PH_T4;
        dad_pkg::PH_T4: phase_q <= dad_pkg::PH_T1;
        default:        phase_q <= dad_pkg::PH_T1;
      endcase
    end
  end

  // Decode the current phase onto the pulse outputs.
  assign t1 = (phase_q == dad_pkg::PH_T1);
  assign t2 = (phase_q == dad_pkg::PH_T2);
  assign t3 = (phase_q == dad_pkg::PH_T3);
  assign t4 = (phase_q == dad_pkg::PH_T4);

endmodule : dad_phase

// ==== design/dad_edge.sv ====
`timescale 1ns/1ps
module dad_edge (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Strobe levels from the same clock domain.
  input  wire logic [2:0] level,
  // Edge pulses.
  output logic [2:0]      rise,
  output logic [2:0]      fall
);

  logic [2:0] prev_q;

  // Remember last level of each strobe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 3'h0;
    end else begin
      prev_q <= level;
    end
  end

  // Compare with the present level for each strobe.
  for (genvar i = 0; i < 3; i++) begin : g_edge
    assign rise[i] = level[i] & ~prev_q[i];
    assign fall[i] = ~level[i] & prev_q[i];
  end

endmodule : dad_edge

// ==== design/dad_counters.sv ====
`timescale 1ns/1ps
// Overview of operation
// RQ1 - Master clear forces the current word address to zero.
// RQ2 - During read, write or compare, word address loads from host data.
// RQ3 - Word address increments on trailing edge of its count strobe.
// RQ4 - Load-buffer instruction loads the words-left counter from host data.
// RQ5 - Words-left decrements on word-need and word-address-load leading edges.
// RQ6 - Extra decrement per operation makes borrow fire on the last word.
// RQ7 - Words-left borrow sets a count-zero flag that ends the transfer.
// RQ8 - Master clear clears the words-left counter.
// RQ9 - Disk address is nine-bit cylinder, five-bit sector, disk and surface bits.
// RQ10 - Load address maps bits 15:7 cylinder, 6 surface, 5 disk, 4:0 sector.
// RQ11 - Load address starting a seek drives the cylinder to the drive.
// RQ12 - Transfer or address-write operations pass the disk address to the shifter.
// RQ13 - Sector counter increments on trailing edge of sector-increment strobe.
// RQ14 - Sector reaching twenty-nine sets track advance at next T3.
// RQ15 - Track advance toggles the surface select bit on the next T2.
// RQ16 - With surface already set, cylinder increments at the next T4.
// RQ17 - Address error when cylinder exceeds limit chosen by unit density.
// RQ18 - With surface set, cylinder-step sets at next T3 and strobes drive.
// RQ19 - Track advance clears the sector counter and itself at following T3; the sector clears at the T3 that sets the flag.
// RQ20 - Master clear resets cylinder, sector, disk and surface bits.
// RQ21 - Status output shows disk address when select low, word address high.
// RQ22 - Flag updates occur in a repeating four-phase T1 to T4 cycle.
module dad_counters (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Controller strobes on this clock.
  input  wire logic        master_clear,
  input  wire logic        word_need_strobe,
  input  wire logic        word_count_strobe,
  input  wire logic        sector_increment_strobe,
  input  wire logic        transfer_or_address_write_op,
  // Drive status pin, asynchronous.
  input  wire logic        unit_density_select,
  // Drive side.
  output logic [8:0]       cylinder_out,
  output logic             seek_strobe,
  output logic             track_address_strobe,
  // Shifter and controller side.
  output logic [15:0]      shifter_addr,
  output logic [15:0]      status_select_out,
  output logic             count_zero,
  output logic             address_error
);

  // Register state.
  logic [15:0] current_word_address_q;
  logic [15:0] words_left_count_q;
  logic [8:0]  cylinder_count_q;
  logic [4:0]  sector_count_q;
  logic        disk_select_bit_q;
  logic        surface_select_bit_q;
  logic        status_source_select_q;
  logic        rwc_active_q;
  logic        count_zero_q;
  logic        wrap_pending_q;
  logic        track_advance_flag_q;
  logic        track_toggled_q;
  logic        wrap_surface_q;
  logic        cylinder_step_flag_q;
  logic        address_error_q;
  logic        seek_q;
  logic [8:0]  cylinder_out_q;
  logic [15:0] shifter_addr_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [1:0]  density_sync_q;

  // Phases and strobe edges.
  logic       t1;
  logic       t2;
  logic       t3;
  logic       t4;
  logic [2:0] strobe_rise;
  logic [2:0] strobe_fall;

  // Bus decode.
  logic apb_done;
  logic wr_ctrl;
  logic wr_word_addr;
  logic wr_words_left;
  logic wr_disk_addr;
  logic wr_status;
  logic mclr;
  logic word_address_load;
  logic words_left_load;
  logic disk_address_load;
  logic words_left_dec;
  logic words_left_borrow;
  logic [15:0] disk_addr_word;
  logic [8:0]  cyl_limit;

  // Address decode that several places share.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] addr);
    mapped = hit(addr, dad_pkg::OFF_CTRL) | hit(addr, dad_pkg::OFF_WORD_ADDR) |
             hit(addr, dad_pkg::OFF_WORDS_LEFT) | hit(addr, dad_pkg::OFF_DISK_ADDR) |
             hit(addr, dad_pkg::OFF_STATUS);
  endfunction : mapped

  dad_phase u_phase (
    .pclk    (pclk),
    .presetn (presetn),
    .t1      (t1),
    .t2      (t2),
    .t3      (t3),
    .t4      (t4)
  );

  dad_edge u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   ({sector_increment_strobe, word_count_strobe, word_need_strobe}),
    .rise    (strobe_rise),
    .fall    (strobe_fall)
  );

  // A transfer completes on the edge where the access phase sees pready.
  assign apb_done      = psel & penable & pready_q;
  assign wr_ctrl       = apb_done & pwrite & hit(paddr, dad_pkg::OFF_CTRL);
  assign wr_word_addr  = apb_done & pwrite & hit(paddr, dad_pkg::OFF_WORD_ADDR);
  assign wr_words_left = apb_done & pwrite & hit(paddr, dad_pkg::OFF_WORDS_LEFT);
  assign wr_disk_addr  = apb_done & pwrite & hit(paddr, dad_pkg::OFF_DISK_ADDR);
  assign wr_status     = apb_done & pwrite & hit(paddr, dad_pkg::OFF_STATUS);

  // Instruction strobes derived from bus writes.
  assign mclr              = master_clear | (wr_ctrl & pwdata[dad_pkg::CTRL_MCLR_BIT]);
  assign word_address_load = wr_word_addr & rwc_active_q; // see RQ2
  assign words_left_load   = wr_words_left; // see RQ4
  assign disk_address_load = wr_disk_addr;

  // Each leading edge of need or address load takes one count off.
  assign words_left_dec    = strobe_rise[0] | word_address_load; // see RQ5
  assign words_left_borrow = words_left_dec & (words_left_count_q == dad_pkg::WORD_RESET); // see RQ6

  // Assembled disk address word, status layout.
  assign disk_addr_word = {cylinder_count_q, surface_select_bit_q, disk_select_bit_q, sector_count_q}; // see RQ9

  // Limit chosen from the synchronised density indication.
  assign cyl_limit = density_sync_q[1] ? dad_pkg::CYL_LIMIT_DENSE : dad_pkg::CYL_LIMIT_STD;

  // Two-stage synchroniser for the drive density pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      density_sync_q <= 2'h0;
    end else begin
      density_sync_q <= {density_sync_q[0], unit_density_select};
    end
  end

  // APB answer: one wait state, read data and error registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (psel & penable & ~pready_q) begin
      pready_q  <= 1'b1;
      pslverr_q <= ~mapped(paddr);
      prdata_q  <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (1'b1)
          hit(paddr, dad_pkg::OFF_CTRL): begin
            prdata_q[dad_pkg::CTRL_SRC_BIT] <= status_source_select_q;
            prdata_q[dad_pkg::CTRL_RWC_BIT] <= rwc_active_q;
          end
          hit(paddr, dad_pkg::OFF_WORD_ADDR):  prdata_q[15:0] <= current_word_address_q;
          hit(paddr, dad_pkg::OFF_WORDS_LEFT): prdata_q[15:0] <= words_left_count_q;
          hit(paddr, dad_pkg::OFF_DISK_ADDR):  prdata_q[15:0] <= disk_addr_word;
          hit(paddr, dad_pkg::OFF_STATUS): begin
            prdata_q[15:0]                   <= status_select_out;
            prdata_q[dad_pkg::STAT_TRACK_BIT] <= track_advance_flag_q;
            prdata_q[dad_pkg::STAT_STEP_BIT]  <= cylinder_step_flag_q;
            prdata_q[dad_pkg::STAT_AERR_BIT]  <= address_error_q;
            prdata_q[dad_pkg::STAT_ZERO_BIT]  <= count_zero_q;
            prdata_q[dad_pkg::STAT_SEEK_BIT]  <= seek_q;
          end
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Control bits written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_source_select_q <= 1'b0;
      rwc_active_q           <= 1'b0;
    end else if (wr_ctrl) begin
      status_source_select_q <= pwdata[dad_pkg::CTRL_SRC_BIT];
      rwc_active_q           <= pwdata[dad_pkg::CTRL_RWC_BIT];
    end
  end

  // Current word address counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_word_address_q <= dad_pkg::WORD_RESET;
    end else if (mclr) begin
      current_word_address_q <= dad_pkg::WORD_RESET; // see RQ1
    end else if (word_address_load) begin
      current_word_address_q <= pwdata[15:0]; // see RQ2
    end else if (strobe_fall[1]) begin
      current_word_address_q <= current_word_address_q + 16'h0001; // see RQ3
    end
  end

  // Words-left counter; wraps below zero like the borrowing counter chain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      words_left_count_q <= dad_pkg::WORD_RESET;
    end else if (mclr) begin
      words_left_count_q <= dad_pkg::WORD_RESET; // see RQ8
    end else if (words_left_load) begin
      words_left_count_q <= pwdata[15:0]; // see RQ4
    end else if (words_left_dec) begin
      words_left_count_q <= words_left_count_q - 16'h0001; // see RQ5
    end
  end

  // Count-zero flag; a borrow in the cycle of a clear still sets it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_zero_q <= 1'b0;
    end else if (words_left_borrow) begin
      count_zero_q <= 1'b1; // see RQ7
    end else if (mclr | words_left_load | (wr_status & pwdata[dad_pkg::STAT_ZERO_BIT])) begin
      count_zero_q <= 1'b0;
    end
  end

  // Sector counter: load, clear on track advance, step on strobe trailing edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sector_count_q <= dad_pkg::SECT_RESET;
    end else if (mclr) begin
      sector_count_q <= dad_pkg::SECT_RESET; // see RQ20
    end else if (disk_address_load) begin
      sector_count_q <= pwdata[dad_pkg::SECT_HI:dad_pkg::SECT_LO]; // see RQ10
    end else if (wrap_pending_q & t3) begin
      sector_count_q <= dad_pkg::SECT_RESET; // see RQ19
    end else if (strobe_fall[2]) begin
      sector_count_q <= sector_count_q + 5'h01; // see RQ13
    end
  end

  // A sector count that reaches the wrap value waits for the next T3.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_pending_q <= 1'b0;
    end else if (mclr | disk_address_load) begin
      wrap_pending_q <= 1'b0;
    end else if (strobe_fall[2] & (sector_count_q + 5'h01 == dad_pkg::SECT_WRAP)) begin
      wrap_pending_q <= 1'b1;
    end else if (t3) begin
      wrap_pending_q <= 1'b0;
    end
  end

  // Track advance flag: set at T3, cleared at the following T3.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      track_advance_flag_q <= 1'b0;
      wrap_surface_q       <= 1'b0;
    end else if (mclr) begin
      track_advance_flag_q <= 1'b0;
      wrap_surface_q       <= 1'b0;
    end else if (t3) begin
      track_advance_flag_q <= wrap_pending_q; // see RQ14, RQ19, RQ22
      wrap_surface_q       <= wrap_pending_q & surface_select_bit_q;
    end
  end

  // Marks that the surface bit has already toggled for this advance.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      track_toggled_q <= 1'b0;
    end else if (mclr | t3) begin
      track_toggled_q <= 1'b0;
    end else if (track_advance_flag_q & t2) begin
      track_toggled_q <= 1'b1;
    end
  end

  // Disk and surface select bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disk_select_bit_q    <= 1'b0;
      surface_select_bit_q <= 1'b0;
    end else if (mclr) begin
      disk_select_bit_q    <= 1'b0; // see RQ20
      surface_select_bit_q <= 1'b0;
    end else if (disk_address_load) begin
      disk_select_bit_q    <= pwdata[dad_pkg::DISK_BIT]; // see RQ10
      surface_select_bit_q <= pwdata[dad_pkg::SURFACE_BIT];
    end else if (track_advance_flag_q & ~track_toggled_q & t2) begin
      surface_select_bit_q <= ~surface_select_bit_q; // see RQ15
    end
  end

  // Cylinder counter steps at T4 when the advance wraps the surface.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cylinder_count_q <= dad_pkg::CYL_RESET;
    end else if (mclr) begin
      cylinder_count_q <= dad_pkg::CYL_RESET; // see RQ20
    end else if (disk_address_load) begin
      cylinder_count_q <= pwdata[dad_pkg::CYL_HI:dad_pkg::CYL_LO]; // see RQ10
    end else if (track_advance_flag_q & wrap_surface_q & ~track_toggled_q & t4) begin
      cylinder_count_q <= cylinder_count_q + 9'h001; // see RQ16
    end
  end

  // Cylinder-step flag: set at the T3 that ends a wrapping advance, three cycles wide.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cylinder_step_flag_q <= 1'b0;
    end else if (mclr) begin
      cylinder_step_flag_q <= 1'b0;
    end else if (t3) begin
      cylinder_step_flag_q <= track_advance_flag_q & wrap_surface_q; // see RQ18
    end else if (t2) begin
      cylinder_step_flag_q <= 1'b0;
    end
  end

  // Address limit check against the selected unit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_error_q <= 1'b0;
    end else begin
      address_error_q <= (cylinder_count_q > cyl_limit); // see RQ17
    end
  end

  // Seek: capture the loaded cylinder for the drive and pulse the seek strobe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cylinder_out_q <= dad_pkg::CYL_RESET;
      seek_q         <= 1'b0;
    end else begin
      seek_q <= disk_address_load;
      if (disk_address_load) begin
        cylinder_out_q <= pwdata[dad_pkg::CYL_HI:dad_pkg::CYL_LO]; // see RQ11
      end else if (track_advance_flag_q & wrap_surface_q & ~track_toggled_q & t4) begin
        cylinder_out_q <= cylinder_count_q + 9'h001;
      end
    end
  end

  // Shifter address copy, refreshed while a transfer or address write runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shifter_addr_q <= dad_pkg::WORD_RESET;
    end else if (transfer_or_address_write_op) begin
      shifter_addr_q <= disk_addr_word; // see RQ12
    end
  end

  // Status multiplexer.
  assign status_select_out = status_source_select_q ? current_word_address_q : disk_addr_word; // see RQ21

  // Output drive.
  assign prdata               = prdata_q;
  assign pready               = pready_q;
  assign pslverr              = pslverr_q;
  assign cylinder_out         = cylinder_out_q;
  assign seek_strobe          = seek_q;
  assign track_address_strobe = cylinder_step_flag_q; // see RQ18
  assign shifter_addr         = shifter_addr_q;
  assign count_zero           = count_zero_q;
  assign address_error        = address_error_q;

endmodule : dad_counters

// ==== test/dad_counters_sva.sv ====
`timescale 1ns/1ps
module dad_counters_sva (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus side.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Controller and drive side.
  input wire logic        master_clear,
  input wire logic [8:0]  cylinder_out,
  input wire logic        seek_strobe,
  input wire logic        track_address_strobe,
  input wire logic        count_zero
);
  // Every check runs on the bus clock and rests during reset.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // The slave answers one cycle into the access phase, and only inside it.
  ready_wait_a: assert property ($rose(penable) && psel |=> pready) else $error("pready late");
  ready_only_a: assert property (pready |-> psel && penable) else $error("pready outside an access");
  // Unmapped places answer with an error and read as zero.
  unmapped_err_a: assert property (pready && paddr > 8'h10 |-> pslverr) else $error("no error for unmapped place");
  err_data_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h00000000)) else $error("bad error answer");
  // An address load hands its cylinder to the drive and strobes the drive once, in the same cycle.
  seek_load_a: assert property (psel && penable && pready && pwrite && paddr == 8'h0C && !master_clear
    |=> cylinder_out == 9'($past(pwdata) >> 7) ##[0:1] seek_strobe) else $error("seek cylinder wrong");
  seek_pulse_a: assert property (seek_strobe |=> !seek_strobe) else $error("seek strobe too long");
  // The count-zero flag only drops after a clear or a bus write.
  zero_hold_a: assert property ($fell(count_zero) |-> $past(master_clear) || $past(pready))
    else $error("count zero dropped");
  mclr_flag_a: assert property (master_clear [*2] |=> !count_zero) else $error("flag kept in clear");
  // The track strobe to the drive is three cycles wide.
  track_width_a: assert property ($rose(track_address_strobe) |->
    track_address_strobe [*3] ##1 !track_address_strobe) else $error("track strobe width wrong");
endmodule : dad_counters_sva

bind dad_counters dad_counters_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .master_clear(master_clear),
  .cylinder_out(cylinder_out), .seek_strobe(seek_strobe), .track_address_strobe(track_address_strobe),
  .count_zero(count_zero)
);

// ==== test/dad_drive_model.sv ====
`timescale 1ns/1ps
module dad_drive_model (
  // Clock.
  input wire logic       pclk,
  // Cylinder and strobes from the controller.
  input wire logic [8:0] cylinder_out,
  input wire logic       seek_strobe,
  input wire logic       track_address_strobe,
  // Density setting of the attached unit.
  input wire logic       dense_unit,
  output logic           unit_density_select
);
  logic [8:0] seek_cyl = 9'h000;
  logic [8:0] step_cyl = 9'h000;
  logic       step_q   = 1'b0;
  int         steps    = 0;
  // The density pin is a plain level from the unit.
  assign unit_density_select = dense_unit;
  // Take the cylinder at a seek, and again when a track step strobe ends.
  always @(posedge pclk) begin
    step_q <= track_address_strobe;
    if (seek_strobe) begin
      seek_cyl <= cylinder_out;
    end
    if (step_q && !track_address_strobe) begin
      step_cyl <= cylinder_out;
      steps    <= steps + 1;
    end
  end
endmodule : dad_drive_model

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        master_clear = 1'b0, word_need_strobe = 1'b0, word_count_strobe = 1'b0;
  logic        sector_increment_strobe = 1'b0, transfer_or_address_write_op = 1'b0, dense_unit = 1'b0;
  logic        unit_density_select, pready, pslverr, rerr, seek_strobe, track_address_strobe;
  logic        count_zero, address_error;
  logic [31:0] prdata, rdat;
  logic [8:0]  cylinder_out;
  logic [15:0] shifter_addr, status_select_out;
  int          num_errors = 0;
  int          num_checks = 0;

  // Bus clock at 200 MHz.
  always #2.5 pclk = ~pclk;

  dad_counters dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clear(master_clear), .word_need_strobe(word_need_strobe), .word_count_strobe(word_count_strobe),
    .sector_increment_strobe(sector_increment_strobe), .transfer_or_address_write_op(transfer_or_address_write_op),
    .unit_density_select(unit_density_select), .cylinder_out(cylinder_out), .seek_strobe(seek_strobe),
    .track_address_strobe(track_address_strobe), .shifter_addr(shifter_addr),
    .status_select_out(status_select_out), .count_zero(count_zero), .address_error(address_error));

  dad_drive_model drive (.pclk(pclk), .cylinder_out(cylinder_out), .seek_strobe(seek_strobe),
    .track_address_strobe(track_address_strobe), .dense_unit(dense_unit), .unit_density_select(unit_density_select));

  // Prints the counts and the verdict, then stops.
  task summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  // Compares one value and reports a mismatch.
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  // One bus transfer: setup, access held until pready, then release.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      num_errors++;
      summarize();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input string nm, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask : rd

  // Raises one strobe for two cycles: 0 word need, 1 word count, 2 sector.
  task pulse(input int k);
    if (k == 0) word_need_strobe <= 1'b1;
    else if (k == 1) word_count_strobe <= 1'b1;
    else sector_increment_strobe <= 1'b1;
    repeat (2) @(posedge pclk);
    word_need_strobe        <= 1'b0;
    word_count_strobe       <= 1'b0;
    sector_increment_strobe <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse

  // Loads a disk address one sector short of the wrap and lets the track advance run.
  task t_adv(input logic [15:0] w, input logic [15:0] e, input int n);
    wr(8'h0C, w);
    pulse(2);
    repeat (20) @(posedge pclk);
    chk("disk word", e, status_select_out);
    chk("track steps", n, drive.steps);
    chk("step cylinder", 32'hCA, drive.step_cyl);
    $display("track advance test done");
  endtask : t_adv

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Values after reset, and an unmapped read.
    rd(8'h04, "word address", 32'h0);
    rd(8'h08, "words left", 32'h0);
    rd(8'h0C, "disk address", 32'h0);
    rd(8'h14, "unmapped read", 32'h0);
    chk("slave error", 32'h1, rerr);
    $display("reset test done");
    // Word address and words-left counting with a borrow at the last word.
    wr(8'h04, 32'hAAAA);
    rd(8'h04, "word address", 32'h0);
    wr(8'h00, 32'h4);
    wr(8'h08, 32'h5);
    rd(8'h08, "words left", 32'h5);
    wr(8'h04, 32'hFFFF);
    rd(8'h04, "word address", 32'hFFFF);
    rd(8'h08, "words left", 32'h4);
    pulse(1);
    rd(8'h04, "word address", 32'h0);
    repeat (4) pulse(0);
    chk("count zero", 32'h0, count_zero);
    pulse(0);
    chk("count zero", 32'h1, count_zero);
    rd(8'h10, "status", 32'h80000);
    wr(8'h10, 32'h80000);
    chk("count zero", 32'h0, count_zero);
    $display("word count test done");
    // Disk address load, seek, shifter copy, sector count and status source.
    wr(8'h0C, 32'h64E3);
    repeat (3) @(posedge pclk);
    chk("seek cylinder", 32'hC9, drive.seek_cyl);
    rd(8'h0C, "disk address", 32'h64E3);
    transfer_or_address_write_op <= 1'b1;
    pulse(2);
    chk("shifter address", 32'h64E4, shifter_addr);
    chk("status select", 32'h64E4, status_select_out);
    wr(8'h00, 32'h6);
    chk("status select", 32'h0, status_select_out);
    wr(8'h00, 32'h4);
    $display("disk address test done");
    t_adv(16'h64FC, 16'h6520, 1);
    t_adv(16'h653C, 16'h6560, 1);
    // Cylinder limit for each unit density.
    chk("address error", 32'h0, address_error);
    wr(8'h0C, 32'h6580);
    repeat (4) @(posedge pclk);
    chk("address error", 32'h1, address_error);
    dense_unit <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("address error", 32'h0, address_error);
    wr(8'h0C, 32'hCB00);
    repeat (4) @(posedge pclk);
    chk("address error", 32'h1, address_error);
    $display("limit test done");
    // Master clear empties every counter.
    wr(8'h04, 32'h12);
    master_clear <= 1'b1;
    repeat (3) @(posedge pclk);
    master_clear <= 1'b0;
    @(posedge pclk);
    rd(8'h04, "word address", 32'h0);
    rd(8'h08, "words left", 32'h0);
    rd(8'h0C, "disk address", 32'h0);
    $display("master clear test done");
    summarize();
  end
endmodule : tb
